// ===== hdl/scrs_top.v
// Purpose: clock gating, reset sequencing, reset cause and flag registers
// Assumes: cpu-side strobes are on ref_clk; pins and detectors are asynchronous
// Notes:   registers reached over APB, one 32-bit word per register
//
// Functional notes
// RULE1 - bus clock is half-oscillator clock divided by two
// RULE2 - power-on/low-voltage: clocks held, pin low 4096
// RULE3 - stop exit waits 4096 or 32 cycles
// RULE4 - wait mode stops cpu, keeps peripheral clocks
// RULE5 - all resets assert internal reset, select vector
// RULE6 - internal reset clears system counter, pin doesn't
// RULE7 - each reset source records its cause bit
// RULE8 - low reset pin halts all processing
// RULE9 - pin cause needs 67 low cycles, not power-on
// RULE10 - internal source: pin low 32, hold 32
// RULE11 - power-on: pin low 4096, release 64 later
// RULE12 - power-on sets only power-on cause, half clock on
// RULE13 - watchdog overflow resets, sets watchdog cause
// RULE14 - write to ffff clears watchdog and stages
// RULE15 - watchdog clock pulses within 2^12 minus 2^4
// RULE16 - watchdog disabled only by test high voltage
// RULE17 - watchdog request independent of bus clock
// RULE18 - illegal instruction sets cause and resets
// RULE19 - stop with stop disallowed is illegal opcode
// RULE20 - unmapped opcode fetch resets, data fetch doesn't
// RULE21 - low voltage: cause, pin low 4096, then 64
// RULE22 - three read-only flag registers, cleared by reset
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`include "scrs_regs.vh"
module scrs_top (
   input  wire        ref_clk,
   input  wire        resetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [17:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // asynchronous pins and detectors
   input  wire        rst_pin_in,
   output reg         rst_pin_out,
   output reg         rst_pin_oe,
   input  wire        power_on_pulse,
   input  wire        low_voltage_detector,
   input  wire        monitor_mode,
   input  wire        test_high_voltage_rst,
   input  wire        test_high_voltage_irq,
   // processor side, same clock
   input  wire        break_state,
   input  wire        bad_opcode,
   input  wire        stop_exec,
   input  wire        wait_exec,
   input  wire        wake_event,
   input  wire        opcode_fetch,
   input  wire        addr_unmapped,
   input  wire        internal_bus_write,
   input  wire [15:0] internal_address_bus,
   input  wire [15:1] source_flags,
   // clocks and reset to the chip
   output reg         half_osc_clock,
   output reg         bus_clk_en,
   output reg         cpu_clk_en,
   output reg         periph_clk_en,
   output reg         internal_reset_signal,
   output reg  [15:0] reset_vector,
   output reg         watchdog_tick
);

// ==========================================================
// states
localparam ST_RUN  = 3'h0;
localparam ST_LONG = 3'h1;
localparam ST_PULL = 3'h2;
localparam ST_HOLD = 3'h3;
localparam ST_EXT  = 3'h4;
localparam ST_STOP = 3'h5;
localparam ST_SREC = 3'h6;
localparam ST_WAIT = 3'h7;

reg  [2:0]  state;
reg  [12:0] seq_cnt;
reg  [12:0] seq_tgt;
reg  [5:0]  cause;
reg  [1:0]  ctrl;
reg  [15:1] flags;
reg  [1:0]  div_cnt;
reg  [11:0] sys_cnt;
reg  [5:0]  wdog_cnt;
reg         wdog_ovf;
reg  [5:0]  sync1;
reg  [5:0]  sync2;
reg  [2:0]  next_state;
reg  [12:0] next_cnt;
reg  [12:0] next_tgt;
reg  [5:0]  next_cause;
reg  [31:0] next_rdata;
reg         next_err;

wire [12:0] seq_inc;
wire        seq_done;
wire        pin_low;
wire        por_req;
wire        lvd_req;
wire        mon_s;
wire        wdog_dis;
wire        internal_reset_signal_int;
wire        live;
wire        opc_req;
wire        adr_req;
wire        feed;
wire        sys_tick;
wire        apb_acc;
wire        apb_wr;
wire [15:0] idx;
wire [7:0]  flags_a;
wire [7:0]  flags_b;
wire [7:0]  flags_c;

// ==========================================================
// synchronisers for pins and detectors
// only the second stage is ever looked at
always @(posedge ref_clk or negedge resetn) begin
   if (!resetn) begin
      sync1 <= `SCRS_SYNC_RST;
      sync2 <= `SCRS_SYNC_RST;
   end else begin
      sync1 <= {rst_pin_in, power_on_pulse, low_voltage_detector,
                monitor_mode, test_high_voltage_rst, test_high_voltage_irq};
      sync2 <= sync1;
   end
end

assign pin_low  = ~sync2[5];                        // see RULE8
assign por_req  = sync2[4];
assign lvd_req  = sync2[3];
assign mon_s    = sync2[2];
// pure gating of test voltage; noise cannot latch a disable
assign wdog_dis = (mon_s & (sync2[1] | sync2[0])) | (break_state & sync2[1]); // see RULE16

// ==========================================================
// event decode
assign live     = (state == ST_RUN) | (state == ST_WAIT) | (state == ST_STOP) | (state == ST_SREC);
assign opc_req  = bad_opcode | (stop_exec & ~ctrl[`SCRS_CTRL_STOP_OK]); // see RULE18 RULE19
assign adr_req  = opcode_fetch & addr_unmapped;     // see RULE20
assign feed     = internal_bus_write & (internal_address_bus == `SCRS_FEED_ADDR); // see RULE14
assign internal_reset_signal_int = (state == ST_LONG) | (state == ST_PULL) | (state == ST_HOLD);
assign seq_inc  = seq_cnt + 13'd1;
assign seq_done = (seq_inc == seq_tgt);

// ==========================================================
// reset and power-mode sequencer
always @* begin
   next_state = state;
   next_cnt   = seq_inc;
   next_tgt   = seq_tgt;
   next_cause = cause;
   if (por_req) begin
      next_state = ST_LONG;                          // see RULE11
      next_cnt   = 13'd0;
      next_tgt   = `SCRS_POR_CYCLES;
      next_cause = `SCRS_CAUSE_RST;                  // see RULE12
   end else if (lvd_req && state != ST_LONG) begin
      next_state = ST_LONG;                          // see RULE21
      next_cnt   = 13'd0;
      next_tgt   = `SCRS_POR_CYCLES;
      next_cause = 6'h00;
      next_cause[`SCRS_CAUSE_LVD] = 1'b1;            // see RULE7
   end else if (live && (wdog_ovf || (state == ST_RUN && (opc_req || adr_req)))) begin
      next_state = ST_PULL;                          // see RULE10
      next_cnt   = 13'd0;
      next_tgt   = `SCRS_PULL_CYCLES;
      next_cause = 6'h00;
      if (wdog_ovf)
         next_cause[`SCRS_CAUSE_WDOG] = 1'b1;        // see RULE13
      else if (opc_req)
         next_cause[`SCRS_CAUSE_OPC] = 1'b1;         // see RULE18
      else
         next_cause[`SCRS_CAUSE_ADR] = 1'b1;         // see RULE20
   end else if (live && pin_low) begin
      next_state = ST_EXT;                           // see RULE8
      next_cnt   = 13'd0;
   end else begin
      case (state)
         ST_RUN: begin
            if (stop_exec) begin
               next_state = ST_STOP;
            end else if (wait_exec) begin
               next_state = ST_WAIT;
            end
         end
         ST_LONG: begin
            if (seq_done) begin
               next_state = ST_HOLD;                 // see RULE2
               next_cnt   = 13'd0;
               next_tgt   = `SCRS_HOLD_LONG;         // see RULE11 RULE21
            end
         end
         ST_PULL: begin
            if (seq_done) begin
               next_state = ST_HOLD;
               next_cnt   = 13'd0;
               next_tgt   = `SCRS_HOLD_SHORT;        // see RULE10
            end
         end
         ST_HOLD: begin
            if (seq_done) begin
               next_state = ST_RUN;
            end
         end
         ST_EXT: begin
            if (!pin_low) begin
               next_state = ST_RUN;
            end else begin
               if (seq_inc == `SCRS_PIN_MIN) begin
                  next_cause = 6'h00;
                  next_cause[`SCRS_CAUSE_PIN] = 1'b1; // see RULE9
                  next_cnt   = seq_cnt;               // saturate once counted
               end
            end
         end
         ST_STOP: begin
            if (wake_event) begin
               next_state = ST_SREC;                 // see RULE3
               next_cnt   = 13'd0;
               next_tgt   = ctrl[`SCRS_CTRL_SSREC] ? `SCRS_STOP_SHORT : `SCRS_STOP_LONG;
            end
         end
         ST_SREC: begin
            if (seq_done) begin
               next_state = ST_RUN;
            end
         end
         ST_WAIT: begin
            if (wake_event) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end
end

// state registers; reset lands in the power-on sequence
// the pin is already driven while resetn is low, so that cycle counts as the first
always @(posedge ref_clk or negedge resetn) begin
   if (!resetn) begin
      state   <= ST_LONG;
      seq_cnt <= 13'd1;
      seq_tgt <= `SCRS_POR_CYCLES;
      cause   <= `SCRS_CAUSE_RST;
   end else begin
      state   <= next_state;
      seq_cnt <= next_cnt;
      seq_tgt <= next_tgt;
      cause   <= next_cause;
   end
end

// ==========================================================
// clock divider; half clock runs even while the core is held
always @(posedge ref_clk or negedge resetn) begin
   if (!resetn) begin
      div_cnt <= 2'h0;
   end else begin
      div_cnt <= div_cnt + 2'h1;                     // see RULE1
   end
end

// ==========================================================
// system counter and watchdog
assign sys_tick = (sys_cnt == `SCRS_SYS_TOP);        // see RULE15

always @(posedge ref_clk or negedge resetn) begin
   if (!resetn) begin
      sys_cnt  <= 12'h000;
      wdog_cnt <= 6'h00;
      wdog_ovf <= 1'b0;
   end else begin
      // pin reset leaves the counter running
      if (internal_reset_signal_int || state == ST_STOP)
         sys_cnt <= 12'h000;                         // see RULE6
      else if (feed)
         sys_cnt <= sys_cnt & `SCRS_FEED_KEEP;       // see RULE14
      else
         sys_cnt <= sys_cnt + 12'h001;
      // overflow acts on any oscillator cycle, not on a bus phase
      wdog_ovf <= 1'b0;
      if (internal_reset_signal_int || feed || wdog_dis) begin
         wdog_cnt <= 6'h00;                          // see RULE14 RULE16
      end else if (sys_tick) begin
         wdog_cnt <= wdog_cnt + 6'h01;
         wdog_ovf <= (wdog_cnt == `SCRS_WDOG_MAX);   // see RULE13 RULE17
      end
   end
end

// ==========================================================
// apb slave; one wait state, then answer
assign idx     = paddr[17:2];
assign apb_acc = psel & penable & pready;
assign apb_wr  = apb_acc & pwrite;
assign flags_a = {flags[6], flags[5], flags[4], flags[3], 1'b0, flags[1], 2'b00}; // see RULE22
assign flags_b = {flags[14], flags[13], flags[12], flags[11], 2'b00, flags[8], flags[7]};
assign flags_c = {7'h00, flags[15]};

// read mux and unmapped answer
always @* begin
   next_rdata = 32'h00000000;
   next_err   = 1'b0;
   if (paddr[1:0] != 2'h0)
      next_err = 1'b1;
   else if (idx == `SCRS_IDX_FLAGS_A)
      next_rdata = {24'h000000, flags_a};
   else if (idx == `SCRS_IDX_FLAGS_B)
      next_rdata = {24'h000000, flags_b};
   else if (idx == `SCRS_IDX_FLAGS_C)
      next_rdata = {24'h000000, flags_c};
   else if (idx == `SCRS_IDX_CAUSE)
      next_rdata = {26'h0, cause};                   // see RULE7
   else if (idx == `SCRS_IDX_CTRL)
      next_rdata = {30'h0, ctrl};
   else
      next_err = 1'b1;
end

always @(posedge ref_clk or negedge resetn) begin
   if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
   end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & ~pwrite) ? next_rdata : 32'h00000000;
      pslverr <= psel & penable & ~pready & next_err;
   end
end

// control register and flag capture; both return to default on internal reset
always @(posedge ref_clk or negedge resetn) begin
   if (!resetn) begin
      ctrl  <= `SCRS_CTRL_RST;
      flags <= `SCRS_FLAGS_RST;
   end else if (internal_reset_signal) begin
      ctrl  <= `SCRS_CTRL_RST;                       // see RULE5
      flags <= `SCRS_FLAGS_RST;                      // see RULE22
   end else begin
      flags <= source_flags;
      if (apb_wr && idx == `SCRS_IDX_CTRL && paddr[1:0] == 2'h0)
         ctrl <= pwdata[1:0];
   end
end

// ==========================================================
// registered outputs
always @(posedge ref_clk or negedge resetn) begin
   if (!resetn) begin
      half_osc_clock        <= 1'b0;
      bus_clk_en            <= 1'b0;
      cpu_clk_en            <= 1'b0;
      periph_clk_en         <= 1'b0;
      internal_reset_signal <= 1'b1;
      rst_pin_out           <= 1'b0;
      rst_pin_oe            <= 1'b1;
      reset_vector          <= `SCRS_VEC_USER;
      watchdog_tick         <= 1'b0;
   end else begin
      half_osc_clock        <= ~div_cnt[0];          // see RULE12
      bus_clk_en            <= (div_cnt == `SCRS_BUS_PHASE); // see RULE1
      cpu_clk_en            <= (div_cnt == `SCRS_BUS_PHASE) & (state == ST_RUN); // see RULE2 RULE3 RULE4
      periph_clk_en         <= (div_cnt == `SCRS_BUS_PHASE) &
                               ((state == ST_RUN) | (state == ST_WAIT)); // see RULE4
      internal_reset_signal <= internal_reset_signal_int | (state == ST_EXT); // see RULE5 RULE8
      rst_pin_out           <= 1'b0;
      rst_pin_oe            <= (state == ST_LONG) | (state == ST_PULL); // see RULE2 RULE10 RULE11
      reset_vector          <= mon_s ? `SCRS_VEC_MON : `SCRS_VEC_USER; // see RULE5
      watchdog_tick         <= sys_tick;             // see RULE15
   end
end

endmodule

// ===== hdl/scrs_regs.vh
// Purpose: constants for the system clock and reset sequencer
// Assumes: osc_internal_clock is ref_clk, 50 MHz
// Notes:   register offsets are indexes; byte address is index times four
`ifndef SCRS_REGS_VH
`define SCRS_REGS_VH
// ==========================================================
// register indexes
`define SCRS_IDX_FLAGS_A  16'hfe04
`define SCRS_IDX_FLAGS_B  16'hfe05
`define SCRS_IDX_FLAGS_C  16'hfe06
`define SCRS_IDX_CAUSE    16'hfe08
`define SCRS_IDX_CTRL     16'hfe09
// ==========================================================
// field positions
`define SCRS_CAUSE_POR    0
`define SCRS_CAUSE_PIN    1
`define SCRS_CAUSE_WDOG   2
`define SCRS_CAUSE_OPC    3
`define SCRS_CAUSE_ADR    4
`define SCRS_CAUSE_LVD    5
`define SCRS_CTRL_STOP_OK 0
`define SCRS_CTRL_SSREC   1
// ==========================================================
// reset values
`define SCRS_CAUSE_RST    6'h01
`define SCRS_CTRL_RST     2'h0
`define SCRS_FLAGS_RST    15'h0
`define SCRS_SYNC_RST     6'h20
// ==========================================================
// timing counts in oscillator cycles
`define SCRS_POR_CYCLES   13'd4096
`define SCRS_PULL_CYCLES  13'd32
`define SCRS_HOLD_LONG    13'd64
`define SCRS_HOLD_SHORT   13'd32
`define SCRS_STOP_LONG    13'd4096
`define SCRS_STOP_SHORT   13'd32
`define SCRS_PIN_MIN      13'd67
`define SCRS_BUS_PHASE    2'h3
// ==========================================================
// counters, addresses, vectors
`define SCRS_SYS_TOP      12'hfff
`define SCRS_FEED_KEEP    12'h00f
`define SCRS_WDOG_MAX     6'h3f
`define SCRS_FEED_ADDR    16'hffff
`define SCRS_VEC_USER     16'hfffe
`define SCRS_VEC_MON      16'hfefe
`endif

// ===== tb/scrs_sva.sv
// Purpose: port checks for the clock and reset sequencer
// Assumes: one clock domain, ref_clk; bound to scrs_top
// Notes:   counters measure pin drive, reset hold and tick gaps
`timescale 1ns/10ps
`include "scrs_regs.vh"
module scrs_sva (
   input wire        ref_clk,
   input wire        resetn,
   input wire        psel,
   input wire        penable,
   input wire [17:0] paddr,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        rst_pin_oe,
   input wire        half_osc_clock,
   input wire        bus_clk_en,
   input wire        cpu_clk_en,
   input wire        periph_clk_en,
   input wire        internal_reset_signal,
   input wire        watchdog_tick
);
   reg [12:0] oe_run;
   reg [12:0] oe_len;
   reg [12:0] hold_run;
   reg        had_oe;
   reg [12:0] gap;
   // ==========================================================
   // phase counters; gap saturates so a long stop cannot wrap it
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         oe_run   <= 13'h0;
         oe_len   <= 13'h0;
         hold_run <= 13'h0;
         had_oe   <= 1'b0;
         gap      <= 13'h0;
      end else begin
         oe_run   <= rst_pin_oe ? oe_run + 13'h1 : 13'h0;
         oe_len   <= (!rst_pin_oe && oe_run != 13'h0) ? oe_run : oe_len;
         hold_run <= (internal_reset_signal && !rst_pin_oe) ? hold_run + 13'h1 : 13'h0;
         had_oe   <= rst_pin_oe || (internal_reset_signal && had_oe);
         // pin-only resets leave the counter alone, so gap keeps running
         gap      <= (watchdog_tick || had_oe) ? 13'h0 : gap + {12'h0, gap != 13'h1fff};
      end
   end
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   // ==========================================================
   // clocks, reset phases, bus
   bus_div_a: assert property (bus_clk_en |=> !bus_clk_en [*3] ##1 bus_clk_en)
      else $error("bus enable not every fourth cycle");
   half_osc_a: assert property ($past(resetn) |-> half_osc_clock != $past(half_osc_clock))
      else $error("half clock stopped toggling");
   halt_clk_a: assert property (internal_reset_signal && $past(internal_reset_signal) |-> !cpu_clk_en && !periph_clk_en)
      else $error("clock enable during reset");
   cpu_sub_a: assert property (cpu_clk_en |-> periph_clk_en)
      else $error("cpu clock without peripheral clock");
   oe_internal_reset_signal_a: assert property (rst_pin_oe |-> internal_reset_signal)
      else $error("pin driven without internal reset");
   oe_len_a: assert property ($fell(rst_pin_oe) |-> oe_run == 13'd32 || oe_run == 13'd4096)
      else $error("pin drive length wrong");
   hold_len_a: assert property ($fell(internal_reset_signal) && had_oe |->
      hold_run == (oe_len == 13'd32 ? 13'd32 : 13'd64))
      else $error("reset hold length wrong");
   apb_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
      else $error("apb wait state wrong");
   flags_ro_a: assert property (pready && !pslverr && paddr == {`SCRS_IDX_FLAGS_A, 2'b00} |->
      prdata[31:8] == 24'h0 && prdata[3] == 1'b0 && prdata[1:0] == 2'b00)
      else $error("flag register spare bits set");
   wtick_gap_a: assert property (watchdog_tick && !had_oe |-> gap >= 13'd4070)
      else $error("watchdog ticks too close");
   cover property (oe_len == 13'd32 && $fell(internal_reset_signal));
   cover property (pready && pslverr);
   cover property (watchdog_tick);
endmodule
bind scrs_top scrs_sva chk_u (.*);

// ===== tb/scrs_cpu_model.sv
// Purpose: processor-side strobes and the open-drain reset pin
// Assumes: pin has a pull-up; strobes last one ref_clk cycle
// Notes:   bench sets ext_low to pull the pin from outside
`timescale 1ns/10ps
module scrs_cpu_model (
   input  wire        ref_clk,
   input  wire        rst_pin_oe,
   output wire        rst_pin_in,
   output reg  [6:0]  ev,
   output wire [15:0] addr
);
   reg ext_low;
   initial ev = 7'h0;
   initial ext_low = 1'b0;
   // ==========================================================
   // wire level: low if anyone pulls, else the pull-up wins
   assign rst_pin_in = !(rst_pin_oe || ext_low);
   assign addr = 16'hffff; // writes go to the service location
   // one cycle strobe of the events in m; idle cycle after so calls never overlap
   task strobe(input [6:0] m);
      begin
         ev <= m;
         @(posedge ref_clk);
         ev <= 7'h0;
         @(posedge ref_clk);
      end
   endtask
endmodule

// ===== tb/system_clock_reset_sequencer_test.sv
// Purpose: self-checking bench for the clock and reset sequencer
// Assumes: ref_clk 50 MHz, registers over APB
// Notes:   watchdog overflow is too long to run; tick gaps are asserted
`timescale 1ns/10ps
`include "scrs_regs.vh"
module system_clock_reset_sequencer_test;
   reg         ref_clk = 1'b0;
   reg         resetn = 1'b0;
   reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   reg  [17:0] paddr = 18'h0;
   reg  [31:0] pwdata = 32'h0, rd, seed = 32'd58391;
   reg         power_on = 1'b0, lvd = 1'b0, mon = 1'b0;
   reg         brk = 1'b0, hvr = 1'b0, hvi = 1'b0;
   reg  [15:1] flags = 15'h0;
   wire [31:0] prdata;
   wire        pready, pslverr, pin_in, pin_oe, cpu_en, per_en, int_rst;
   wire        half_clk, bus_en, pin_out;
   wire [15:0] vec, internal_bus_addr;
   wire [6:0]  ev;
   integer     failures = 0, n_tests = 0, n, k, i;
   always #10 ref_clk = ~ref_clk;
   scrs_top dut_u (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rst_pin_in(pin_in), .rst_pin_out(pin_out), .rst_pin_oe(pin_oe), .power_on_pulse(power_on),
      .low_voltage_detector(lvd), .monitor_mode(mon), .test_high_voltage_rst(hvr),
      .test_high_voltage_irq(hvi), .break_state(brk), .bad_opcode(ev[0]), .stop_exec(ev[1]),
      .wait_exec(ev[2]), .wake_event(ev[3]), .opcode_fetch(ev[4]), .addr_unmapped(ev[5]),
      .internal_bus_write(ev[6]), .internal_address_bus(internal_bus_addr), .source_flags(flags), .half_osc_clock(half_clk),
      .bus_clk_en(bus_en), .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .internal_reset_signal(int_rst),
      .reset_vector(vec), .watchdog_tick());
   scrs_cpu_model cpu_u (.ref_clk(ref_clk), .rst_pin_oe(pin_oe), .rst_pin_in(pin_in), .ev(ev), .addr(internal_bus_addr));
   // ==========================================================
   // helpers
   function [31:0] xs(input [31:0] v);
      reg [31:0] t;
      begin
         t = v ^ (v << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   // expected flag register contents
   function [31:0] fexp(input integer w, input [15:1] f);
      begin
         case (w)
            0: fexp = {24'h0, f[6:3], 1'b0, f[1], 2'b00};
            1: fexp = {24'h0, f[14:11], 2'b00, f[8:7]};
            default: fexp = {31'h0, f[15]};
         endcase
      end
   endfunction
   task summarize;
      begin
         $display("checks %0d failures %0d", n_tests, failures);
         if (failures == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
         end else begin
            $display("Run complete: FAIL");
         end
         $finish;
      end
   endtask
   task chk(input [8*12-1:0] nm, input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("mismatch %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task tick(input integer c);
      begin
         repeat (c) @(posedge ref_clk);
      end
   endtask
   // a wait that ran to its bound ends the run
   task bound(input integer c);
      begin
         if (c >= 9000) begin
            failures = failures + 1;
            summarize;
         end
      end
   endtask
   // one apb transfer; idle cycle after so strobes never double up
   task apb(input w, input [15:0] ix, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= {ix, 2'b00};
         pwdata <= d;
         @(posedge ref_clk);
         penable <= 1'b1;
         k = 0;
         @(posedge ref_clk);
         while (pready !== 1'b1 && k < 50) begin
            @(posedge ref_clk);
            k = k + 1;
         end
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge ref_clk);
         bound(k * 180);
      end
   endtask
   task rdc(input [15:0] ix, input [31:0] e, input [8*12-1:0] nm);
      begin
         apb(1'b0, ix, 32'h0);
         chk(nm, rd, e);
      end
   endtask
   // wait for count of pin drive and reset hold cycles
   task meas(input integer e_oe, input integer e_hold);
      begin
         n = 0;
         while (pin_oe !== 1'b1 && n < 20) begin
            tick(1);
            n = n + 1;
         end
         for (n = 0; pin_oe === 1'b1 && n < 9000; n = n + 1) tick(1);
         chk("pin_drive", n, e_oe);
         bound(n);
         for (n = 0; int_rst === 1'b1 && n < 9000; n = n + 1) tick(1);
         chk("reset_hold", n, e_hold);
         bound(n);
      end
   endtask
   // stop then wake; recovery must last the chosen count
   task stopw(input integer lim);
      begin
         cpu_u.strobe(7'h02);
         tick(20);
         cpu_u.strobe(7'h08);
         for (n = 0; cpu_en !== 1'b1 && n < 9000; n = n + 1) tick(1);
         chk("stop_wake", n >= lim && n <= lim + 8, 1);
      end
   endtask
   // ==========================================================
   // main sequence
   initial begin
      tick(20);
      resetn <= 1'b1;
      tick(1);
      meas(4096, 64);
      chk("vector", vec, `SCRS_VEC_USER);
      rdc(`SCRS_IDX_CAUSE, 32'h01, "cause");
      cpu_u.strobe(7'h40);
      for (i = 0; i < 6; i = i + 1) begin
         seed = xs(seed);
         flags <= seed[15:1];
         {brk, hvr, hvi} <= seed[18:16];
         tick(3);
         rdc(`SCRS_IDX_FLAGS_A, fexp(0, flags), "flags_a");
         rdc(`SCRS_IDX_FLAGS_B, fexp(1, flags), "flags_b");
         rdc(`SCRS_IDX_FLAGS_C, fexp(2, flags), "flags_c");
      end
      {brk, hvr, hvi} <= 3'h0;
      apb(1'b1, `SCRS_IDX_FLAGS_A, seed);
      rdc(`SCRS_IDX_FLAGS_A, fexp(0, flags), "flags_ro");
      apb(1'b0, 16'hfe07, 32'h0);
      chk("slverr", {31'h0, err}, 32'h1);
      chk("slv_data", rd, 32'h0);
      apb(1'b1, `SCRS_IDX_CTRL, 32'h3);
      rdc(`SCRS_IDX_CTRL, 32'h3, "ctrl");
      cpu_u.strobe(7'h04);
      tick(2);
      for (i = 0, n = 0; i < 16; i = i + 1) begin
         tick(1);
         n = n + cpu_en + 16 * per_en + 256 * bus_en + 4096 * half_clk;
      end
      chk("wait_clks", n, 4 * 16 + 4 * 256 + 8 * 4096);
      cpu_u.strobe(7'h08);
      stopw(32);
      apb(1'b1, `SCRS_IDX_CTRL, 32'h1);
      stopw(4096);
      for (i = 0; i < 3; i = i + 1) begin
         tick(10);
         cpu_u.strobe(i == 0 ? 7'h01 : i == 1 ? 7'h02 : 7'h30);
         meas(32, 32);
         tick(8);
         rdc(`SCRS_IDX_CAUSE, i == 2 ? 32'h10 : 32'h08, "cause");
      end
      cpu_u.strobe(7'h20);
      tick(10);
      chk("data_fetch", pin_oe, 0);
      lvd <= 1'b1;
      tick(3);
      lvd <= 1'b0;
      meas(4096, 64);
      rdc(`SCRS_IDX_CAUSE, 32'h20, "cause");
      cpu_u.ext_low <= 1'b1;
      tick(30);
      cpu_u.ext_low <= 1'b0;
      tick(20);
      rdc(`SCRS_IDX_CAUSE, 32'h20, "cause");
      cpu_u.ext_low <= 1'b1;
      tick(10);
      chk("pin_halt", {int_rst, pin_oe, pin_out}, 3'b100);
      tick(70);
      cpu_u.ext_low <= 1'b0;
      for (n = 0; int_rst !== 1'b0 && n < 9000; n = n + 1) tick(1);
      bound(n);
      tick(4);
      rdc(`SCRS_IDX_CAUSE, 32'h02, "cause");
      mon <= 1'b1;
      tick(6);
      chk("vector", vec, `SCRS_VEC_MON);
      mon <= 1'b0;
      power_on <= 1'b1;
      tick(1);
      power_on <= 1'b0;
      meas(4096, 64);
      rdc(`SCRS_IDX_CAUSE, 32'h01, "cause");
      summarize;
   end
endmodule
